//--- usbir_consts.vh
`ifndef USBIR_CONSTS_VH
`define USBIR_CONSTS_VH

// Register offsets, as seen on the plain register port
`define USBIR_ADDR_W 8
`define USBIR_OFF_RX_FLAGS 8'h04
`define USBIR_OFF_RX_IRQ_EN 8'h08
`define USBIR_OFF_BUS_FLAGS 8'h0a
`define USBIR_OFF_BUS_IRQ_EN 8'h0b
`define USBIR_OFF_FRAME 8'h0c
`define USBIR_OFF_BUS_CLEAR 8'h20
`define USBIR_OFF_RX_CLEAR 8'h21
`define USBIR_OFF_LINK_STATE 8'h22

// Field widths and writable masks
`define USBIR_FLAG_W 6
`define USBIR_FRAME_W 11
`define USBIR_RX_EN_MASK 6'h3e
`define USBIR_BUS_EN_MASK 6'h2f

// Reset values
`define USBIR_RX_EN_RST 6'h3e
`define USBIR_BUS_EN_RST 6'h06
`define USBIR_FRAME_RST 11'h000

// Bit positions inside the bus-event flag and enable registers
`define USBIR_BIT_SUSPEND 0
`define USBIR_BIT_RESUME 1
`define USBIR_BIT_RESET 2
`define USBIR_BIT_SOF 3
`define USBIR_BIT_SESSION_END 5

// Bit position inside the link state register
`define USBIR_BIT_SUSPENDED 0

`endif

//--- usbir_flag_bank.v
`default_nettype none

// Sticky event flags; a set in the same cycle as a clear wins
module usbir_flag_bank #(
  parameter W = 6
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  // Set and clear requests, one bit per flag
  input wire [W-1:0] i_set,
  input wire [W-1:0] i_clr,
  // Current flags
  output wire [W-1:0] o_flags
);

  reg [W-1:0] flags_q;
  reg [W-1:0] flags_d;

  // Set wins so no event is lost to a racing clear
  always @* begin
    flags_d = (flags_q & ~i_clr) | i_set;
  end

  // Flag storage
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_q <= {W{1'b0}};
    end else begin
      flags_q <= flags_d;
    end
  end

  assign o_flags = flags_q;

endmodule // usbir_flag_bank

`default_nettype wire

//--- usbir_frame_cap.v
`include "usbir_consts.vh"
`default_nettype none

// Holds the frame number carried by the latest start of frame
module usbir_frame_cap (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  // Start of frame strobe with its frame number
  input wire i_sof,
  input wire [`USBIR_FRAME_W-1:0] i_frame_num,
  // Last received frame number
  output wire [`USBIR_FRAME_W-1:0] o_frame
);

  reg [`USBIR_FRAME_W-1:0] frame_q;
  reg [`USBIR_FRAME_W-1:0] frame_d;

  // Only a start of frame updates the number
  always @* begin
    frame_d = frame_q;
    if (i_sof) begin
      frame_d = i_frame_num;
    end
  end

  // Frame number storage
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_q <= `USBIR_FRAME_RST;
    end else begin
      frame_q <= frame_d;
    end
  end

  assign o_frame = frame_q;

endmodule // usbir_frame_cap

`default_nettype wire

//--- usbir_regs.v
// Design decision made here: the plain strobed port.
`include "usbir_consts.vh"
`default_nettype none

// Interrupt, enable and frame registers of the device controller
module usbir_regs (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,

  // Register port
  input wire [`USBIR_ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [31:0] o_rdata,

  // Endpoint receive events, endpoints 5 down to 1
  input wire [4:0] i_ep_rx_event,

  // Bus events from the controller's own link logic
  input wire i_session_end,
  input wire i_sof,
  input wire [`USBIR_FRAME_W-1:0] i_frame_num,
  input wire i_bus_reset,
  input wire i_resume,
  input wire i_suspend,

  // Interrupt and link state
  output wire o_usb_irq,
  output wire o_suspended
);

  // Address match, used by every strobe decode below; the read data case compares i_addr itself
  // One place to change if the decode ever widens
  function hit;
    input [`USBIR_ADDR_W-1:0] addr;
    input [`USBIR_ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Widen a six-bit field into a bus word
  // Upper bits read as zero, as reserved bits must
  function [31:0] word6;
    input [`USBIR_FLAG_W-1:0] v;
    begin
      word6 = {26'h0000000, v};
    end
  endfunction

  // Decoded strobes
  // Exact 8-bit compare, so no offset aliases
  wire rd_rx_flags;
  wire rd_bus_flags;
  wire wr_rx_en;
  wire wr_bus_en;
  wire wr_bus_clear;
  wire wr_rx_clear;

  assign rd_rx_flags = i_rd & hit(i_addr, `USBIR_OFF_RX_FLAGS);
  assign rd_bus_flags = i_rd & hit(i_addr, `USBIR_OFF_BUS_FLAGS);
  assign wr_rx_en = i_wr & hit(i_addr, `USBIR_OFF_RX_IRQ_EN);
  assign wr_bus_en = i_wr & hit(i_addr, `USBIR_OFF_BUS_IRQ_EN);
  assign wr_bus_clear = i_wr & hit(i_addr, `USBIR_OFF_BUS_CLEAR);
  assign wr_rx_clear = i_wr & hit(i_addr, `USBIR_OFF_RX_CLEAR);

  // Suspend tracking
  reg suspended_q;
  reg suspended_d;

  // Suspend enters the state; resume or a bus reset leaves it.
  // A suspend seen with a resume in the same cycle is taken as the later event.
  always @* begin
    suspended_d = suspended_q;
    if (i_resume | i_bus_reset) begin
      suspended_d = 1'b0;
    end
    if (i_suspend) begin
      suspended_d = 1'b1;
    end
  end

  // Suspend state register
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      suspended_q <= 1'b0;
    end else begin
      suspended_q <= suspended_d;
    end
  end

  // Bus-event flag set vector
  reg [`USBIR_FLAG_W-1:0] bus_set;

  // Resume only counts while the link sits in suspend
  // Events are same-clock pulses; a long pulse keeps setting
  always @* begin
    bus_set = {`USBIR_FLAG_W{1'b0}};
    bus_set[`USBIR_BIT_SESSION_END] = i_session_end;
    bus_set[`USBIR_BIT_SOF] = i_sof;
    bus_set[`USBIR_BIT_RESET] = i_bus_reset;
    bus_set[`USBIR_BIT_RESUME] = i_resume & suspended_q;
    bus_set[`USBIR_BIT_SUSPEND] = i_suspend;
  end

  // Bus-event flag clear vector: a read of the bus flags, or a write of ones
  reg [`USBIR_FLAG_W-1:0] bus_clr;

  // A read clears every bit; the clear register works by mask
  always @* begin
    bus_clr = {`USBIR_FLAG_W{1'b0}};
    if (rd_bus_flags) begin
      bus_clr = {`USBIR_FLAG_W{1'b1}};
    end
    if (wr_bus_clear) begin
      bus_clr = bus_clr | i_wdata[`USBIR_FLAG_W-1:0];
    end
  end

  // Bus-event flags as stored
  wire [`USBIR_FLAG_W-1:0] bus_flags;

  // Reserved bit 4 never sets since its set input stays low
  usbir_flag_bank #(
    .W(`USBIR_FLAG_W)
  ) u_bus_flags (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_set(bus_set),
    .i_clr(bus_clr),
    .o_flags(bus_flags)
  );

  // Endpoint receive flags; bit 0 stays reserved at zero
  wire [`USBIR_FLAG_W-1:0] rx_set;
  reg [`USBIR_FLAG_W-1:0] rx_clr;
  wire [`USBIR_FLAG_W-1:0] rx_flags;

  assign rx_set = {i_ep_rx_event, 1'b0};

  // Enable writes never reach this clear, so flags survive them
  always @* begin
    rx_clr = {`USBIR_FLAG_W{1'b0}};
    if (rd_rx_flags) begin
      rx_clr = {`USBIR_FLAG_W{1'b1}};
    end
    if (wr_rx_clear) begin
      rx_clr = rx_clr | i_wdata[`USBIR_FLAG_W-1:0];
    end
  end

  // Same set-wins bank as the bus events
  usbir_flag_bank #(
    .W(`USBIR_FLAG_W)
  ) u_rx_flags (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_set(rx_set),
    .i_clr(rx_clr),
    .o_flags(rx_flags)
  );

  // Interrupt enable registers
  reg [`USBIR_FLAG_W-1:0] rx_en_q;
  reg [`USBIR_FLAG_W-1:0] rx_en_d;
  reg [`USBIR_FLAG_W-1:0] bus_en_q;
  reg [`USBIR_FLAG_W-1:0] bus_en_d;

  // Reserved bits are masked off so they always read back as zero
  // A write replaces the whole field, so software keeps a copy
  always @* begin
    rx_en_d = rx_en_q;
    bus_en_d = bus_en_q;
    if (wr_rx_en) begin
      rx_en_d = i_wdata[`USBIR_FLAG_W-1:0] & `USBIR_RX_EN_MASK;
    end
    if (wr_bus_en) begin
      bus_en_d = i_wdata[`USBIR_FLAG_W-1:0] & `USBIR_BUS_EN_MASK;
    end
  end

  // Enable storage with its reset defaults
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_en_q <= `USBIR_RX_EN_RST;
      bus_en_q <= `USBIR_BUS_EN_RST;
    end else begin
      rx_en_q <= rx_en_d;
      bus_en_q <= bus_en_d;
    end
  end

  // Frame number capture
  // Only a start of frame moves it; writes are ignored
  wire [`USBIR_FRAME_W-1:0] frame;

  usbir_frame_cap u_frame (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_sof(i_sof),
    .i_frame_num(i_frame_num),
    .o_frame(frame)
  );

  // Interrupt combine
  reg irq_q;
  reg irq_d;
  reg [`USBIR_FLAG_W-1:0] bus_pend;
  reg [`USBIR_FLAG_W-1:0] rx_pend;

  // Registered so the line never glitches; costs one cycle of latency
  // Each bus-event enable gates only its own flag
  always @* begin
    rx_pend = rx_flags & rx_en_q;
    bus_pend = {`USBIR_FLAG_W{1'b0}};
    bus_pend[`USBIR_BIT_SESSION_END] =
      bus_flags[`USBIR_BIT_SESSION_END] & bus_en_q[`USBIR_BIT_SESSION_END];
    bus_pend[`USBIR_BIT_SOF] =
      bus_flags[`USBIR_BIT_SOF] & bus_en_q[`USBIR_BIT_SOF];
    bus_pend[`USBIR_BIT_RESET] =
      bus_flags[`USBIR_BIT_RESET] & bus_en_q[`USBIR_BIT_RESET];
    bus_pend[`USBIR_BIT_RESUME] =
      bus_flags[`USBIR_BIT_RESUME] & bus_en_q[`USBIR_BIT_RESUME];
    bus_pend[`USBIR_BIT_SUSPEND] =
      bus_flags[`USBIR_BIT_SUSPEND] & bus_en_q[`USBIR_BIT_SUSPEND];
    irq_d = (|rx_pend) | (|bus_pend);
  end

  // Interrupt line register
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Read data path
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // Values are sampled before the read's own clear lands.
  // Write-only and unmapped offsets read as zero.
  always @* begin
    rdata_d = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        `USBIR_OFF_RX_FLAGS: begin
          rdata_d = word6(rx_flags);
        end
        `USBIR_OFF_RX_IRQ_EN: begin
          rdata_d = word6(rx_en_q);
        end
        `USBIR_OFF_BUS_FLAGS: begin
          rdata_d = word6(bus_flags);
        end
        `USBIR_OFF_BUS_IRQ_EN: begin
          rdata_d = word6(bus_en_q);
        end
        `USBIR_OFF_FRAME: begin
          rdata_d = {21'h000000, frame};
        end
        `USBIR_OFF_LINK_STATE: begin
          rdata_d[`USBIR_BIT_SUSPENDED] = suspended_q;
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  // Cleared when idle so stale data never looks like a read
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs come straight from flip-flops
  assign o_rdata = rdata_q;
  assign o_usb_irq = irq_q;
  assign o_suspended = suspended_q;

endmodule // usbir_regs

`default_nettype wire

//--- usbir_regs_props.sv
`include "usbir_consts.vh"
`default_nettype none
module usbir_regs_props (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  // Register port
  input wire [`USBIR_ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  // Events
  input wire [4:0] i_ep_rx_event,
  input wire i_session_end,
  input wire i_sof,
  input wire [`USBIR_FRAME_W-1:0] i_frame_num,
  input wire i_bus_reset,
  input wire i_resume,
  input wire i_suspend,
  // Interrupt and link state
  input wire o_usb_irq,
  input wire o_suspended
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Any bus event in this cycle
  wire ev_any = i_session_end | i_sof | i_bus_reset | i_resume | i_suspend;
  sequence s_rd_bus;
    i_rd && i_addr == `USBIR_OFF_BUS_FLAGS;
  endsequence
  sequence s_quiet_rd;
    i_rd && i_addr == `USBIR_OFF_BUS_FLAGS && !ev_any;
  endsequence
  // Read two cycles after the event must see its flag
  property p_sets(ev, int b);
    ev ##2 s_rd_bus |=> o_rdata[b];
  endproperty
  a_rdata_idle_zero: assert property (o_rdata != 32'h0 |-> $past(i_rd))
    else $error("read data outside read slot");
  a_session_flag_set: assert property (p_sets(i_session_end, 5))
    else $error("session end flag missing");
  a_sof_flag_set: assert property (p_sets(i_sof, 3))
    else $error("frame start flag missing");
  a_reset_flag_set: assert property (p_sets(i_bus_reset, 2))
    else $error("bus reset flag missing");
  a_suspend_flag_set: assert property (p_sets(i_suspend, 0))
    else $error("suspend flag missing");
  a_resume_flag_set: assert property (i_resume && o_suspended ##2 s_rd_bus |=> o_rdata[1])
    else $error("resume flag missing");
  a_read_clears_flags: assert property (s_quiet_rd ##1 !ev_any ##1 s_quiet_rd |=> o_rdata[5:0] == 6'h0)
    else $error("flags not cleared by read");
  a_frame_number_held: assert property (i_sof ##2 (i_rd && i_addr == `USBIR_OFF_FRAME)
    |=> o_rdata == {21'h0, $past(i_frame_num, 3)})
    else $error("frame number wrong");
  a_irq_has_cause: assert property ($rose(o_usb_irq)
    |-> $past(ev_any || i_ep_rx_event != 5'h0 || i_wr, 2))
    else $error("interrupt rose without cause");
endmodule // usbir_regs_props
bind usbir_regs usbir_regs_props chk_u (.i_sys_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_ep_rx_event, .i_session_end, .i_sof, .i_frame_num, .i_bus_reset,
  .i_resume, .i_suspend, .o_usb_irq, .o_suspended);
`default_nettype wire

//--- usbir_host_model.sv
`default_nettype none
module usbir_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Bus events toward the device
  output logic o_session_end,
  output logic o_sof,
  output logic o_bus_reset,
  output logic o_resume,
  output logic o_suspend,
  output var logic [10:0] o_frame_num
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ev_q = 6'h0;
  // Event lines follow the flag bit layout
  assign {o_session_end, o_sof, o_bus_reset, o_resume, o_suspend} = {ev_q[5], ev_q[3:0]};
  initial o_frame_num = 11'h5a5;
  // One cycle pulse; the number is stale outside the pulse, so it is inverted
  task automatic pulse(input int b, input logic [10:0] fn);
    @(posedge i_sys_clk);
    ev_q <= 6'h1 << b;
    o_frame_num <= fn;
    @(posedge i_sys_clk);
    ev_q <= 6'h0;
    o_frame_num <= ~fn;
  endtask
endmodule // usbir_host_model
`default_nettype wire

//--- testbench.sv
`include "usbir_consts.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_t = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [4:0] i_ep_rx_event = 5'h0;
  logic [4:0] m;
  logic [10:0] fn;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  wire [31:0] o_rdata;
  wire [10:0] i_frame_num;
  wire o_usb_irq, o_suspended, i_session_end, i_sof, i_bus_reset, i_resume, i_suspend;
  int n_errors = 0;
  int checked = 0;
  int bits[5] = '{0, 1, 2, 3, 5};
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  usbir_regs dut_u (.i_sys_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ep_rx_event, .i_session_end, .i_sof, .i_frame_num, .i_bus_reset, .i_resume,
    .i_suspend, .o_usb_irq, .o_suspended);
  usbir_host_model host_u (.i_sys_clk, .o_session_end(i_session_end), .o_sof(i_sof),
    .o_bus_reset(i_bus_reset), .o_resume(i_resume), .o_suspend(i_suspend),
    .o_frame_num(i_frame_num));
  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t line %b expected %b", $time, got, exp);
    end
  endtask
  // Lets edges pass, then settles on the falling edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(x);
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge i_sys_clk) rd_t <= i_rd;
  always @(negedge i_sys_clk) begin
    if (rd_t) begin
      chk(o_rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (4000) @(posedge i_sys_clk);
    n_errors++;
    $display("ERROR %0t run too long", $time);
    give_verdict();
  end
  initial begin
    void'($urandom(13));
    repeat (5) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    // Reset values, a read-only write and an unmapped hole
    wr(`USBIR_OFF_FRAME, 32'h7ff);
    rd(`USBIR_OFF_RX_IRQ_EN, 32'h3e);
    rd(`USBIR_OFF_BUS_IRQ_EN, 32'h6);
    rd(`USBIR_OFF_FRAME, 32'h0);
    rd(8'h30, 32'h0);
    // Resume while awake is refused
    host_u.pulse(1, 11'h0);
    rd(`USBIR_OFF_BUS_FLAGS, 32'h0);
    // Each bus event, masked then enabled; resume needs a suspend first
    foreach (bits[i]) begin
      e = (bits[i] == 1) ? 32'h3 : 32'h1 << bits[i];
      wr(`USBIR_OFF_BUS_IRQ_EN, 32'h0);
      if (bits[i] == 1) host_u.pulse(0, 11'h0);
      host_u.pulse(bits[i], 11'h0);
      tick(2);
      chk1(o_usb_irq, 1'b0);
      rd(`USBIR_OFF_BUS_FLAGS, e);
      wr(`USBIR_OFF_BUS_IRQ_EN, 32'h1 << bits[i]);
      if (bits[i] == 1) host_u.pulse(0, 11'h0);
      host_u.pulse(bits[i], 11'h0);
      rd(`USBIR_OFF_BUS_FLAGS, e);
      tick(0);
      chk1(o_usb_irq, 1'b1);
      rd(`USBIR_OFF_BUS_FLAGS, 32'h0);
      tick(0);
      chk1(o_usb_irq, 1'b0);
    end
    // Random frame number
    fn = 11'($urandom);
    host_u.pulse(3, fn);
    rd(`USBIR_OFF_FRAME, {21'h0, fn});
    rd(`USBIR_OFF_BUS_FLAGS, 32'h8);
    // Endpoint events; dropping the enable must keep the flags
    m = 5'($urandom) | 5'h1;
    @(posedge i_sys_clk);
    i_ep_rx_event <= m;
    @(posedge i_sys_clk);
    i_ep_rx_event <= 5'h0;
    tick(2);
    chk1(o_usb_irq, 1'b1);
    wr(`USBIR_OFF_RX_IRQ_EN, 32'h0);
    tick(2);
    chk1(o_usb_irq, 1'b0);
    rd(`USBIR_OFF_RX_FLAGS, {26'h0, m, 1'b0});
    // Link state, write-one clears, and a clear racing a new event
    host_u.pulse(0, 11'h0);
    rd(`USBIR_OFF_LINK_STATE, 32'h1);
    tick(0);
    chk1(o_suspended, 1'b1);
    wr(`USBIR_OFF_BUS_CLEAR, 32'h1);
    rd(`USBIR_OFF_BUS_FLAGS, 32'h0);
    fork
      host_u.pulse(2, 11'h0);
      wr(`USBIR_OFF_BUS_CLEAR, 32'h4);
    join
    rd(`USBIR_OFF_BUS_FLAGS, 32'h4);
    tick(0);
    chk1(o_suspended, 1'b0);
    // Endpoint 2 event, then its write-one clear
    @(posedge i_sys_clk);
    i_ep_rx_event <= 5'h2;
    @(posedge i_sys_clk);
    i_ep_rx_event <= 5'h0;
    wr(`USBIR_OFF_RX_CLEAR, 32'h4);
    rd(`USBIR_OFF_RX_FLAGS, 32'h0);
    // Reset in mid-run brings back the enable defaults
    @(posedge i_sys_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    rd(`USBIR_OFF_RX_IRQ_EN, 32'h3e);
    rd(`USBIR_OFF_BUS_IRQ_EN, 32'h6);
    tick(3);
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("ERROR %0t reads left unchecked", $time);
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
